// file: logic/sbc_pkg.sv
`default_nettype none
package sbc_pkg;
    // Byte I/O map
    localparam logic [2:0] ADDR_STATUS = 3'h0;
    localparam logic [2:0] ADDR_CONTROL = 3'h1;
    localparam logic [2:0] ADDR_PENDING = 3'h2;
    localparam logic [2:0] ADDR_VECTOR = 3'h3;
    localparam logic [7:0] READ_UNMAPPED = 8'h00;

    // Reset values: strobes low, clock and CTS inactive
    localparam logic [7:0] CONTROL_RESET = 8'h70;
    localparam logic [7:0] VECTOR_RESET = 8'h40;
    localparam logic [7:0] VECTOR_TRAP = 8'hFF;
    localparam logic [6:0] PINS_IDLE = 7'h7F;
    localparam logic [4:0] PEND_RESET = 5'h00;

    // Control port bits
    localparam int BIT_NMI_CLR = 0;
    localparam int BIT_BUS_INT = 1;
    localparam int BIT_DMA_RST = 2;
    localparam int BIT_LINE_SEL = 3;
    localparam int BIT_NETCLK_N = 4;
    localparam int BIT_CTS7_N = 5;
    localparam int BIT_CTS8_N = 6;
    localparam int BIT_RED = 7;

    // Status port bits
    localparam int IN_TIMEOUT = 0;
    localparam int IN_ATTN = 1;
    localparam int IN_DMA_DONE = 2;
    localparam int IN_LOC_PERR = 3;
    localparam int IN_SYS_ERR = 4;
    localparam int IN_STANDALONE = 5;
    localparam int IN_MASTER = 6;

    // Vector cause codes of the counter/IO controller
    localparam logic [2:0] CAUSE_CT3 = 3'h0;
    localparam logic [2:0] CAUSE_TIMEOUT = 3'h1;
    localparam logic [2:0] CAUSE_ATTN = 3'h2;
    localparam logic [2:0] CAUSE_DMA = 3'h3;
    localparam logic [2:0] CAUSE_CT2 = 3'h4;
    localparam logic [2:0] CAUSE_CT1 = 3'h5;

    // Serial controller 0 cause codes
    localparam logic [1:0] SCC0_A_RX = 2'h0;
    localparam logic [1:0] SCC0_A_TX = 2'h1;
    localparam logic [1:0] SCC0_A_EXT = 2'h2;
    localparam logic [1:0] SCC0_B = 2'h3;

    localparam int NUM_SRC = 14;

    typedef struct packed {
        logic master_board_n;
        logic standalone_jumper_n;
        logic system_error_n;
        logic local_parity_error_n;
        logic dma_done_n;
        logic channel_attention_n;
        logic bus_timeout_n;
    } sbc_pins_t;

    typedef struct packed {
        logic valid;
        logic [7:0] vector;
    } sbc_ack_t;
endpackage
`default_nettype wire

// file: logic/sbc_status_control.sv
`timescale 1ns/1ps
`default_nettype none
module sbc_status_control (
    // Clock and reset
    input wire logic core_clk,
    input wire logic reset_n,
    // Byte I/O from the local processor
    input wire logic io_sel,
    input wire logic io_wr,
    input wire logic io_rd,
    input wire logic [2:0] io_addr,
    input wire logic [7:0] io_wdata,
    output logic [7:0] io_rdata,
    // Board pins into the status port
    input wire sbc_pkg::sbc_pins_t status_pins,
    // Control port outputs
    output logic parity_nmi_clear,
    output logic bus_interrupt_strobe,
    output logic dma_reset_strobe,
    output logic network_line_select,
    output logic rs422_rx_enable,
    output logic rs232_rx_enable_n,
    output logic network_clock_enable_n,
    output logic chan7_cts_n,
    output logic chan8_cts_n,
    output logic red_indicator,
    output logic parity_nmi,
    // Counter/timer requests, index is timer number
    input wire logic [3:1] ct_irq,
    // Serial controllers: 0 split as A rx, A tx, A ext, B
    input wire logic [3:0] scc0_irq,
    input wire logic [4:1] scc_irq,
    input wire logic [4:0][7:0] scc_vec,
    // Interrupt acknowledge
    output logic int_req,
    input wire logic int_ack,
    output sbc_pkg::sbc_ack_t ack_out
);
    default clocking @(posedge core_clk);
    endclocking
    default disable iff (!reset_n);

    sbc_pkg::sbc_pins_t pins_s;
    sbc_pkg::sbc_pins_t pins_d_ff;
    logic [7:0] ctrl_ff;
    logic [7:0] nxt_ctrl;
    logic [7:0] vbase_ff;
    logic [7:0] nxt_vbase;
    logic [4:0] pend_ff;
    logic [4:0] nxt_pend;
    logic [4:0] fall;
    logic [4:0] clr_bits;
    logic nmi_ff;
    logic nxt_nmi;
    logic bus_stb_ff;
    logic nxt_bus_stb;
    logic dma_stb_ff;
    logic nxt_dma_stb;
    logic [7:0] rdata_ff;
    logic [7:0] nxt_rdata;
    sbc_pkg::sbc_ack_t ack_ff;
    sbc_pkg::sbc_ack_t nxt_ack;
    logic [2:0] vec_pend;
    logic [sbc_pkg::NUM_SRC-1:0] src_req;
    logic [sbc_pkg::NUM_SRC-1:0][7:0] src_vec;
    logic [7:0] sel_vec;
    logic found;
    logic wr_ctrl;
    logic wr_pend;
    logic wr_vec;

    // Pins come from another clock domain
    sbc_sync u_sync (
        .core_clk(core_clk),
        .reset_n(reset_n),
        .pins_in(status_pins),
        .pins_out(pins_s)
    );

    assign wr_ctrl = io_sel && io_wr && (io_addr == sbc_pkg::ADDR_CONTROL);
    assign wr_pend = io_sel && io_wr && (io_addr == sbc_pkg::ADDR_PENDING);
    assign wr_vec = io_sel && io_wr && (io_addr == sbc_pkg::ADDR_VECTOR);

    // Control port and strobes
    always_comb begin
        nxt_ctrl = ctrl_ff;
        nxt_vbase = vbase_ff;
        if (wr_ctrl) begin
            nxt_ctrl = io_wdata;
        end
        if (wr_vec) begin
            nxt_vbase = io_wdata;
        end
        // Strobe only on the closing high-to-low, so a level alone does nothing
        nxt_bus_stb = ctrl_ff[sbc_pkg::BIT_BUS_INT] && !nxt_ctrl[sbc_pkg::BIT_BUS_INT];
        nxt_dma_stb = ctrl_ff[sbc_pkg::BIT_DMA_RST] && !nxt_ctrl[sbc_pkg::BIT_DMA_RST];
    end

    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            ctrl_ff <= sbc_pkg::CONTROL_RESET;
            vbase_ff <= sbc_pkg::VECTOR_RESET;
            bus_stb_ff <= 1'b0;
            dma_stb_ff <= 1'b0;
        end else begin
            ctrl_ff <= nxt_ctrl;
            vbase_ff <= nxt_vbase;
            bus_stb_ff <= nxt_bus_stb;
            dma_stb_ff <= nxt_dma_stb;
        end
    end

    assign parity_nmi_clear = ctrl_ff[sbc_pkg::BIT_NMI_CLR];
    assign bus_interrupt_strobe = bus_stb_ff;
    assign dma_reset_strobe = dma_stb_ff;
    assign network_line_select = ctrl_ff[sbc_pkg::BIT_LINE_SEL];
    assign rs422_rx_enable = ctrl_ff[sbc_pkg::BIT_LINE_SEL];
    assign rs232_rx_enable_n = ctrl_ff[sbc_pkg::BIT_LINE_SEL];
    assign network_clock_enable_n = ctrl_ff[sbc_pkg::BIT_NETCLK_N];
    assign chan7_cts_n = ctrl_ff[sbc_pkg::BIT_CTS7_N];
    assign chan8_cts_n = ctrl_ff[sbc_pkg::BIT_CTS8_N];
    assign red_indicator = ctrl_ff[sbc_pkg::BIT_RED];

    // Falling-edge capture and parity NMI latch
    always_comb begin
        fall = pins_d_ff[4:0] & ~pins_s[4:0];
        clr_bits = wr_pend ? io_wdata[4:0] : sbc_pkg::PEND_RESET;
        // A new edge in the clearing cycle survives the clear
        nxt_pend = (pend_ff & ~clr_bits) | fall;
        // Clear holds the latch off for as long as the bit stays high
        if (ctrl_ff[sbc_pkg::BIT_NMI_CLR]) begin
            nxt_nmi = 1'b0;
        end else begin
            nxt_nmi = nmi_ff || fall[sbc_pkg::IN_LOC_PERR] || fall[sbc_pkg::IN_SYS_ERR];
        end
    end

    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            pins_d_ff <= sbc_pkg::PINS_IDLE;
            pend_ff <= sbc_pkg::PEND_RESET;
            nmi_ff <= 1'b0;
        end else begin
            pins_d_ff <= pins_s;
            pend_ff <= nxt_pend;
            nmi_ff <= nxt_nmi;
        end
    end

    assign parity_nmi = nmi_ff;

    // Only the three vectored inputs reach the chain
    assign vec_pend = pend_ff[sbc_pkg::IN_DMA_DONE:sbc_pkg::IN_TIMEOUT];

    // Index 0 is the highest priority
    assign src_req = {scc_irq[4], scc_irq[3], scc_irq[2], scc_irq[1],
                      scc0_irq[3], scc0_irq[2], scc0_irq[1], scc0_irq[0],
                      ct_irq[1], ct_irq[2], vec_pend[2], vec_pend[1], vec_pend[0],
                      ct_irq[3]};
    assign src_vec = {scc_vec[4], scc_vec[3], scc_vec[2], scc_vec[1],
                      {scc_vec[0][7:2], sbc_pkg::SCC0_B},
                      {scc_vec[0][7:2], sbc_pkg::SCC0_A_EXT},
                      {scc_vec[0][7:2], sbc_pkg::SCC0_A_TX},
                      {scc_vec[0][7:2], sbc_pkg::SCC0_A_RX},
                      {vbase_ff[7:3], sbc_pkg::CAUSE_CT1},
                      {vbase_ff[7:3], sbc_pkg::CAUSE_CT2},
                      {vbase_ff[7:3], sbc_pkg::CAUSE_DMA},
                      {vbase_ff[7:3], sbc_pkg::CAUSE_ATTN},
                      {vbase_ff[7:3], sbc_pkg::CAUSE_TIMEOUT},
                      {vbase_ff[7:3], sbc_pkg::CAUSE_CT3}};
    assign int_req = |src_req;

    // Daisy chain and acknowledge
    always_comb begin
        found = 1'b0;
        // An acknowledge with nobody asking returns the trap vector
        sel_vec = sbc_pkg::VECTOR_TRAP;
        for (int i = 0; i < sbc_pkg::NUM_SRC; i++) begin
            if (!found && src_req[i]) begin
                found = 1'b1;
                sel_vec = src_vec[i];
            end
        end
        nxt_ack.valid = int_ack;
        nxt_ack.vector = int_ack ? sel_vec : ack_ff.vector;
    end

    // Read data
    always_comb begin
        nxt_rdata = rdata_ff;
        if (io_sel && io_rd) begin
            if (io_addr == sbc_pkg::ADDR_STATUS) begin
                nxt_rdata = {1'b0, pins_s[sbc_pkg::IN_MASTER:sbc_pkg::IN_STANDALONE],
                             pend_ff};
            end else if (io_addr == sbc_pkg::ADDR_CONTROL) begin
                nxt_rdata = ctrl_ff;
            end else if (io_addr == sbc_pkg::ADDR_PENDING) begin
                nxt_rdata = {3'h0, pend_ff};
            end else if (io_addr == sbc_pkg::ADDR_VECTOR) begin
                nxt_rdata = vbase_ff;
            end else begin
                nxt_rdata = sbc_pkg::READ_UNMAPPED;
            end
        end
    end

    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            ack_ff <= '0;
            rdata_ff <= sbc_pkg::READ_UNMAPPED;
        end else begin
            ack_ff <= nxt_ack;
            rdata_ff <= nxt_rdata;
        end
    end

    assign ack_out = ack_ff;
    assign io_rdata = rdata_ff;

    // Checks
    nmi_clear_a: assert property (
        parity_nmi_clear |=> !parity_nmi)
        else $error("parity NMI set while clear held");

    bus_strobe_a: assert property (
        bus_interrupt_strobe |-> $past(ctrl_ff[sbc_pkg::BIT_BUS_INT])
            && !ctrl_ff[sbc_pkg::BIT_BUS_INT])
        else $error("bus interrupt strobe without 1-0 step");

    dma_strobe_a: assert property (
        $fell(ctrl_ff[sbc_pkg::BIT_DMA_RST]) |-> dma_reset_strobe ##1 !dma_reset_strobe)
        else $error("DMA reset strobe missing or too long");

    line_select_a: assert property (
        wr_ctrl |=> rs422_rx_enable == $past(io_wdata[sbc_pkg::BIT_LINE_SEL])
            && rs232_rx_enable_n == rs422_rx_enable)
        else $error("receiver select wrong after write");

    net_clock_a: assert property (
        wr_ctrl |=> network_clock_enable_n == $past(io_wdata[sbc_pkg::BIT_NETCLK_N]))
        else $error("network clock enable wrong after write");

    cts_outputs_a: assert property (
        wr_ctrl |=> chan7_cts_n == $past(io_wdata[sbc_pkg::BIT_CTS7_N])
            && chan8_cts_n == $past(io_wdata[sbc_pkg::BIT_CTS8_N]))
        else $error("CTS output wrong after write");

    red_led_a: assert property (
        wr_ctrl |=> red_indicator == $past(io_wdata[sbc_pkg::BIT_RED]))
        else $error("red indicator wrong after write");

    timeout_catch_a: assert property (
        $fell(status_pins.bus_timeout_n) |-> ##[1:4] pend_ff[sbc_pkg::IN_TIMEOUT])
        else $error("bus timeout edge not captured");

    pending_hold_a: assert property (
        pend_ff[sbc_pkg::IN_ATTN] && !wr_pend |=> pend_ff[sbc_pkg::IN_ATTN])
        else $error("attention pending lost without clear");

    dma_vector_a: assert property (
        int_ack && !ct_irq[3] && vec_pend == 3'h4
            |=> ack_out.valid && ack_out.vector == {vbase_ff[7:3], sbc_pkg::CAUSE_DMA})
        else $error("DMA done vector wrong");

    parity_nmi_a: assert property (
        $fell(status_pins.local_parity_error_n) ##1 !parity_nmi_clear [*4] |-> parity_nmi)
        else $error("local parity error did not raise NMI");

    // Status-only pending bits must leave the request line low
    system_error_n_novec_a: assert property (
        pend_ff[sbc_pkg::IN_DMA_DONE:sbc_pkg::IN_TIMEOUT] == '0 && ct_irq == '0
            && scc0_irq == '0 && scc_irq == '0 |-> !int_req)
        else $error("status-only error raised a vectored request");

    chain_top_a: assert property (
        int_ack && ct_irq[3] |=> ack_out.vector[2:0] == sbc_pkg::CAUSE_CT3)
        else $error("timer 3 not served first");

    trap_vector_a: assert property (
        int_ack && !int_req |=> ack_out.vector == sbc_pkg::VECTOR_TRAP)
        else $error("empty acknowledge did not return trap");

    bus_pulse_a: assert property (
        bus_interrupt_strobe |=> !bus_interrupt_strobe)
        else $error("bus interrupt strobe longer than one cycle");

    edge_set_a: assert property (
        fall[sbc_pkg::IN_TIMEOUT] |=> pend_ff[sbc_pkg::IN_TIMEOUT])
        else $error("timeout edge lost in its capture cycle");

    jumper_read_a: assert property (
        io_sel && io_rd && io_addr == sbc_pkg::ADDR_STATUS
            |=> io_rdata[sbc_pkg::IN_MASTER:sbc_pkg::IN_STANDALONE]
            == $past(pins_s[sbc_pkg::IN_MASTER:sbc_pkg::IN_STANDALONE]))
        else $error("jumper levels read wrong");

    scc0_order_a: assert property (
        int_ack && src_req[5:0] == '0 && scc0_irq[0]
            |=> ack_out.vector[1:0] == sbc_pkg::SCC0_A_RX)
        else $error("serial 0 receive not served first");

    ack_valid_a: assert property (
        int_ack |=> ack_out.valid)
        else $error("acknowledge not answered");

    nmi_raise_c: cover property ($rose(parity_nmi));
    bus_strobe_c: cover property (bus_interrupt_strobe);
    scc_ack_c: cover property (int_ack && !(|src_req[7:0]) && scc_irq[2] ##1 ack_out.valid);
    clear_race_c: cover property (wr_pend && io_wdata[0] && fall[0]);
endmodule // sbc_status_control
`default_nettype wire

// file: logic/sbc_sync.sv
`timescale 1ns/1ps
`default_nettype none
module sbc_sync (
    // Clock and reset
    input wire logic core_clk,
    input wire logic reset_n,
    // Pins in, synchronised out
    input wire sbc_pkg::sbc_pins_t pins_in,
    output sbc_pkg::sbc_pins_t pins_out
);
    sbc_pkg::sbc_pins_t meta_ff;
    sbc_pkg::sbc_pins_t sync_ff;

    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            meta_ff <= sbc_pkg::PINS_IDLE;
            sync_ff <= sbc_pkg::PINS_IDLE;
        end else begin
            meta_ff <= pins_in;
            sync_ff <= meta_ff;
        end
    end

    assign pins_out = sync_ff;
endmodule // sbc_sync
`default_nettype wire

// file: verif/sbc_cpu_model.sv
`timescale 1ns/1ps
`default_nettype none
module sbc_cpu_model #(
    parameter int RECOVERY_CYC = 63
) (
    // Clock
    input wire logic core_clk,
    // Byte I/O master side
    output logic io_sel,
    output logic io_wr,
    output logic io_rd,
    output logic [2:0] io_addr,
    output logic [7:0] io_wdata,
    input wire logic [7:0] io_rdata
);
    initial begin
        io_sel = 1'h0;
        io_wr = 1'h0;
        io_rd = 1'h0;
        io_addr = 3'h7;
        io_wdata = 8'hA5;
    end

    // One byte access, then the idle gap the controller needs
    task automatic access(input logic wr, input logic [2:0] a, input logic [7:0] d,
                          output logic [7:0] q);
        @(negedge core_clk);
        io_sel = 1'h1;
        io_wr = wr;
        io_rd = !wr;
        io_addr = a;
        io_wdata = d;
        @(negedge core_clk);
        q = io_rdata;
        io_sel = 1'h0;
        io_wr = 1'h0;
        io_rd = 1'h0;
        // Released bus must not look like the last access
        io_addr = ~a;
        io_wdata = ~d;
        repeat (RECOVERY_CYC) @(negedge core_clk);
    endtask
endmodule // sbc_cpu_model
`default_nettype wire

// file: verif/serial_board_status_control_ports_tb.sv
`timescale 1ns/1ps
`default_nettype none
module serial_board_status_control_ports_tb;
    logic core_clk, reset_n, io_sel, io_wr, io_rd, int_ack, int_req, parity_nmi;
    logic [2:0] io_addr;
    logic [7:0] io_wdata, io_rdata, q, d, vb;
    sbc_pkg::sbc_pins_t status_pins;
    logic parity_nmi_clear, bus_interrupt_strobe, dma_reset_strobe, network_line_select;
    logic rs422_rx_enable, rs232_rx_enable_n, network_clock_enable_n;
    logic chan7_cts_n, chan8_cts_n, red_indicator;
    logic [3:1] ct_irq;
    logic [3:0] scc0_irq;
    logic [4:1] scc_irq;
    logic [4:0][7:0] scc_vec;
    sbc_pkg::sbc_ack_t ack_out;
    logic [31:0] seed = 32'h24;
    logic [31:0] r;
    int error_cnt = 0;
    int checked = 0;
    int bi_cnt = 0;
    int dr_cnt = 0;
    int c0, c1;

    sbc_status_control uut (.core_clk(core_clk), .reset_n(reset_n), .io_sel(io_sel),
        .io_wr(io_wr), .io_rd(io_rd), .io_addr(io_addr), .io_wdata(io_wdata),
        .io_rdata(io_rdata), .status_pins(status_pins), .parity_nmi_clear(parity_nmi_clear),
        .bus_interrupt_strobe(bus_interrupt_strobe), .dma_reset_strobe(dma_reset_strobe),
        .network_line_select(network_line_select), .rs422_rx_enable(rs422_rx_enable),
        .rs232_rx_enable_n(rs232_rx_enable_n), .network_clock_enable_n(network_clock_enable_n),
        .chan7_cts_n(chan7_cts_n), .chan8_cts_n(chan8_cts_n), .red_indicator(red_indicator),
        .parity_nmi(parity_nmi), .ct_irq(ct_irq), .scc0_irq(scc0_irq), .scc_irq(scc_irq),
        .scc_vec(scc_vec), .int_req(int_req), .int_ack(int_ack), .ack_out(ack_out));

    sbc_cpu_model cpu (.core_clk(core_clk), .io_sel(io_sel), .io_wr(io_wr), .io_rd(io_rd),
        .io_addr(io_addr), .io_wdata(io_wdata), .io_rdata(io_rdata));

    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction

    // Daisy chain as seen at the acknowledge edge
    function automatic logic [7:0] exp_vec(input logic [7:0] base, input logic [2:0] pa);
        if (ct_irq[3]) return {base[7:3], sbc_pkg::CAUSE_CT3};
        if (pa[0]) return {base[7:3], sbc_pkg::CAUSE_TIMEOUT};
        if (pa[1]) return {base[7:3], sbc_pkg::CAUSE_ATTN};
        if (pa[2]) return {base[7:3], sbc_pkg::CAUSE_DMA};
        if (ct_irq[2]) return {base[7:3], sbc_pkg::CAUSE_CT2};
        if (ct_irq[1]) return {base[7:3], sbc_pkg::CAUSE_CT1};
        for (int i = 0; i < 4; i++) if (scc0_irq[i]) return {scc_vec[0][7:2], 2'(i)};
        for (int i = 1; i < 5; i++) if (scc_irq[i]) return scc_vec[i];
        return sbc_pkg::VECTOR_TRAP;
    endfunction

    task automatic complete_run();
        $display("Mismatches %0d, comparisons %0d", error_cnt, checked);
        if (error_cnt == 0 && checked > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    task automatic cmp8(input logic [7:0] got, input logic [7:0] exp);
        checked++;
        if (got !== exp) begin
            error_cnt++;
            $display("MISMATCH %0t byte %h expected %h", $time, got, exp);
        end
    endtask

    task automatic cmp1(input logic got, input logic exp);
        checked++;
        if (got !== exp) begin
            error_cnt++;
            $display("MISMATCH %0t bit %b expected %b", $time, got, exp);
        end
    endtask

    task automatic wr(input logic [2:0] a, input logic [7:0] v);
        logic [7:0] unused;
        cpu.access(1'h1, a, v, unused);
    endtask

    task automatic rd(input logic [2:0] a, output logic [7:0] v);
        cpu.access(1'h0, a, 8'h00, v);
    endtask

    task automatic ack(input logic [7:0] exp);
        @(negedge core_clk);
        int_ack = 1'h1;
        @(negedge core_clk);
        int_ack = 1'h0;
        cmp1(ack_out.valid, 1'h1);
        cmp8(ack_out.vector, exp);
        @(negedge core_clk);
        cmp1(ack_out.valid, 1'h0);
    endtask

    task automatic pulse(input int b);
        @(negedge core_clk);
        status_pins[b] = 1'h0;
        @(negedge core_clk);
        status_pins[b] = 1'h1;
        repeat (5) @(negedge core_clk);
    endtask

    // Sampled mid-cycle, away from the edge that launches the strobes
    always @(negedge core_clk) begin
        if (bus_interrupt_strobe === 1'h1) bi_cnt++;
        if (dma_reset_strobe === 1'h1) dr_cnt++;
    end

    initial begin
        core_clk = 1'h0;
        forever #10 core_clk = ~core_clk;
    end

    initial begin
        repeat (100000) @(posedge core_clk);
        error_cnt++;
        complete_run();
    end

    initial begin
        reset_n = 1'h0;
        status_pins = sbc_pkg::PINS_IDLE;
        ct_irq = 3'h0;
        scc0_irq = 4'h0;
        scc_irq = 4'h0;
        int_ack = 1'h0;
        for (int i = 0; i < 5; i++) scc_vec[i] = 8'(rnd());
        repeat (12) @(negedge core_clk);
        reset_n = 1'h1;
        cmp1(network_clock_enable_n, 1'h1);
        cmp1(parity_nmi, 1'h0);
        wr(3'h5, 8'h8F);
        rd(sbc_pkg::ADDR_CONTROL, q);
        cmp8(q, sbc_pkg::CONTROL_RESET);
        rd(sbc_pkg::ADDR_VECTOR, q);
        cmp8(q & 8'hF8, sbc_pkg::VECTOR_RESET & 8'hF8);
        rd(3'h5, q);
        cmp8(q, sbc_pkg::READ_UNMAPPED);
        ack(sbc_pkg::VECTOR_TRAP);
        // Control levels, strobe bits held low
        for (int n = 0; n < 8; n++) begin
            d = (n == 0) ? 8'h89 : 8'(rnd()) & 8'hF9;
            wr(sbc_pkg::ADDR_CONTROL, d);
            cmp1(parity_nmi_clear, d[0]);
            cmp1(network_line_select, d[3]);
            cmp1(rs422_rx_enable, d[3]);
            cmp1(rs232_rx_enable_n, d[3]);
            cmp1(network_clock_enable_n, d[4]);
            cmp1(chan7_cts_n, d[5]);
            cmp1(chan8_cts_n, d[6]);
            cmp1(red_indicator, d[7]);
            rd(sbc_pkg::ADDR_CONTROL, q);
            cmp8(q, d);
        end
        wr(sbc_pkg::ADDR_CONTROL, 8'h70);
        // A high level alone must not fire a strobe
        for (int b = 1; b < 3; b++) begin
            c0 = bi_cnt;
            c1 = dr_cnt;
            wr(sbc_pkg::ADDR_CONTROL, 8'h70 | (8'h01 << b));
            cmp8(8'(bi_cnt - c0 + dr_cnt - c1), 8'h00);
            wr(sbc_pkg::ADDR_CONTROL, 8'h70);
            cmp8(8'(bi_cnt - c0), 8'(b == 1));
            cmp8(8'(dr_cnt - c1), 8'(b == 2));
        end
        vb = {5'(4 + rnd() % 27), 3'h0};
        wr(sbc_pkg::ADDR_VECTOR, vb);
        for (int b = 0; b < 5; b++) begin
            pulse(b);
            rd(sbc_pkg::ADDR_STATUS, q);
            cmp8(q, 8'h60 | (8'h01 << b));
            cmp1(int_req, b < 3);
            cmp1(parity_nmi, b > 2);
            if (b < 3) begin
                @(negedge core_clk);
                scc_irq = 4'hF;
                ack(exp_vec(vb, 3'(1 << b)));
                scc_irq = 4'h0;
            end else begin
                wr(sbc_pkg::ADDR_CONTROL, 8'h71);
                wr(sbc_pkg::ADDR_CONTROL, 8'h70);
                cmp1(parity_nmi, 1'h0);
            end
            wr(sbc_pkg::ADDR_PENDING, 8'h01 << b);
            rd(sbc_pkg::ADDR_PENDING, q);
            cmp8(q, 8'h00);
        end
        // Clear held high: error still captured, no NMI
        wr(sbc_pkg::ADDR_CONTROL, 8'h71);
        pulse(3);
        cmp1(parity_nmi, 1'h0);
        rd(sbc_pkg::ADDR_PENDING, q);
        cmp8(q, 8'h08);
        wr(sbc_pkg::ADDR_CONTROL, 8'h70);
        wr(sbc_pkg::ADDR_PENDING, 8'h08);
        for (int n = 0; n < 4; n++) begin
            r = rnd();
            @(negedge core_clk);
            status_pins[5] = r[0];
            status_pins[6] = r[1];
            // Two synchroniser stages before the read edge sees the jumpers
            repeat (2) @(negedge core_clk);
            rd(sbc_pkg::ADDR_STATUS, q);
            cmp8(q, {2'h0, r[1:0], 4'h0} << 1);
        end
        for (int n = 0; n < 40; n++) begin
            r = rnd() & rnd();
            @(negedge core_clk);
            ct_irq = r[2:0];
            scc0_irq = r[6:3];
            scc_irq = r[10:7];
            @(negedge core_clk);
            cmp1(int_req, |r[10:0]);
            ack(exp_vec(vb, 3'h0));
        end
        complete_run();
    end
endmodule // serial_board_status_control_ports_tb
`default_nettype wire
